/* File: hw/qdac_frame_rx.sv */
`timescale 1ns/10ps
module qdac_frame_rx (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // serial pins, asynchronous to aclk
  input  wire logic                  frame_sel_n,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_data_in,
  output wire logic                  serial_data_out,
  output wire logic                  serial_data_out_oe,
  // readback and chain control
  input  wire logic                  rb_arm,
  input  wire logic [qdac_pkg::FRAME_BITS-1:0] rb_word,
  input  wire logic                  chain_enable,
  // completed frame
  output wire logic                  frame_done,
  output wire logic [qdac_pkg::FRAME_BITS-1:0] frame_word,
  output wire logic                  frame_sel_high
);
  import qdac_pkg::*;

  logic [2:0]            cs_q, sck_q;   // sync stages plus edge stage
  logic [1:0]            sdi_q;         // sync stages
  logic [FRAME_BITS-1:0] sr_q;          // input shift register
  logic [FRAME_BITS-1:0] tx_q;          // readback shift register
  logic                  rb_act_q;      // readback owns this frame
  logic                  sdo_q;
  logic                  done_q;
  logic                  sck_fall, sck_rise, cs_fall, cs_rise;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // two flops before any logic; stage 0 feeds stage 1 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q  <= 3'h7;
      sck_q <= 3'h0;
      sdi_q <= 2'h0;
    end else begin
      cs_q  <= {cs_q[1:0], frame_sel_n};
      sck_q <= {sck_q[1:0], serial_clk};
      sdi_q <= {sdi_q[0], serial_data_in};
    end
  end

  // edges are judged on stages 1 and 2 only
  assign sck_fall = sck_q[2] & ~sck_q[1];
  assign sck_rise = ~sck_q[2] & sck_q[1];
  assign cs_fall  = cs_q[2] & ~cs_q[1];
  assign cs_rise  = ~cs_q[2] & cs_q[1];

  // sample on falling serial clock while selected, msb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q <= '0;
    end else if (cs_fall) begin
      sr_q <= '0;                                // fresh frame
    end else if (sck_fall && !cs_q[1]) begin
      sr_q <= {sr_q[FRAME_BITS-2:0], sdi_q[1]};
    end
  end

  // frame ends on the select rising edge, whatever the bit count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cs_rise;
    end
  end

  // readback word is captured as the frame opens
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_act_q <= 1'b0;
      tx_q     <= '0;
    end else if (cs_fall) begin
      rb_act_q <= rb_arm;
      tx_q     <= rb_word;
    end else if (sck_rise && !cs_q[1]) begin
      tx_q     <= {tx_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  // output changes on rising serial clock, valid at the next fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdo_q <= 1'b0;
    end else if (sck_rise && !cs_q[1]) begin
      sdo_q <= rb_act_q ? tx_q[FRAME_BITS-1] : sr_q[FRAME_BITS-1];
    end
  end

  assign serial_data_out    = sdo_q;
  assign serial_data_out_oe = !cs_q[1] && (chain_enable || rb_act_q);
  assign frame_done         = done_q;
  assign frame_word         = sr_q;
  assign frame_sel_high     = cs_q[1];

  chk_shift_msb_first: assert property (
    sck_fall && !cs_q[1] && !cs_fall |=> sr_q == {$past(sr_q[FRAME_BITS-2:0]), $past(sdi_q[1])})
    else $error("shift register did not take msb first");
  chk_frame_end_exec: assert property (
    cs_rise |=> done_q ##1 !done_q)
    else $error("frame end pulse missing or stretched");
endmodule

/* File: hw/qdac_top.sv */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module qdac_top #(
  parameter int RES_BITS = qdac_pkg::RES_DEF   // 16, 14 or 12
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // serial pins
  input  wire logic                      frame_sel_n,
  input  wire logic                      serial_clk,
  input  wire logic                      serial_data_in,
  output wire logic                      serial_data_out,
  output wire logic                      serial_data_out_oe,
  // static pins
  input  wire logic                      load_strobe_n,
  input  wire logic                      gain_sel,
  // converter side
  output wire logic [qdac_pkg::NCH-1:0][qdac_pkg::DW-1:0] out_code,
  output wire logic [qdac_pkg::PWR_W-1:0] power_mode,
  output wire logic                      ref_enable,
  output wire logic                      gain_two,
  output wire logic                      chain_enable,
  // axi4-lite write
  input  wire logic                      awvalid,
  output wire logic                      awready,
  input  wire logic [qdac_pkg::AW-1:0]   awaddr,
  input  wire logic                      wvalid,
  output wire logic                      wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  output wire logic                      bvalid,
  input  wire logic                      bready,
  output wire logic [1:0]                bresp,
  // axi4-lite read
  input  wire logic                      arvalid,
  output wire logic                      arready,
  input  wire logic [qdac_pkg::AW-1:0]   araddr,
  output wire logic                      rvalid,
  input  wire logic                      rready,
  output wire logic [31:0]               rdata,
  output wire logic [1:0]                rresp
);
  import qdac_pkg::*;

  // pad bits below the code are forced to zero
  localparam logic [DW-1:0] CODE_MASK = 16'hFFFF << (DW - RES_BITS);

  logic [NCH-1:0][DW-1:0] in_q, out_q;    // input and output code banks
  logic [PWR_W-1:0]       pwr_q;          // power mode pairs
  logic [NCH-1:0]         lmask_q;        // channels ignoring the load pin
  logic                   ref_en_q, chain_q;
  logic                   rb_arm_q;       // next frame carries readback
  logic [1:0]             rb_sel_q;       // channel to read back
  logic [7:0]             frm_cnt_q;      // frames executed, diagnostic
  logic [1:0]             load_strobe_n_q, gain_q; // pin synchronisers
  logic                   bvalid_q, rvalid_q;
  logic [1:0]             bresp_q, rresp_q;
  logic [31:0]            rdata_q;
  // frame receiver outputs
  logic                   exec, cs_high;
  logic [FRAME_BITS-1:0]  fw;
  // decoded fields
  logic [3:0]             cmd;
  logic [NCH-1:0]         chm;
  logic [DW-1:0]          code;
  logic                   wr_fire, rd_fire, ctrl_wr, srst, swload, hw_load;
  logic [31:0]            rd_mux;
  logic                   rd_err;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  qdac_frame_rx u_rx (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .frame_sel_n        (frame_sel_n),
    .serial_clk         (serial_clk),
    .serial_data_in     (serial_data_in),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .rb_arm             (rb_arm_q),
    .rb_word            ({{PAD_W{1'b0}}, out_q[rb_sel_q], {PAD_W{1'b0}}}),
    .chain_enable       (chain_q),
    .frame_done         (exec),
    .frame_word         (fw),
    .frame_sel_high     (cs_high)
  );

  // field split of the received word
  assign cmd  = fw[FRAME_BITS-1:CMD_LSB];
  assign chm  = fw[CMD_LSB-1:MASK_LSB];
  assign code = fw[DW-1:0] & CODE_MASK;

  // load and gain pins are asynchronous levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_strobe_n_q <= 2'h3;
      gain_q <= 2'h0;
    end else begin
      load_strobe_n_q <= {load_strobe_n_q[0], load_strobe_n};
      gain_q <= {gain_q[0], gain_sel};
    end
  end

  // software sources of reset and load
  assign ctrl_wr = wr_fire && awaddr == ADDR_CTRL && wstrb[0];
  assign srst    = (exec && cmd == QDAC_CMD_SRST) || (ctrl_wr && wdata[CTRL_SRST]);
  assign swload  = ctrl_wr && wdata[CTRL_LOAD];
  // load pin only acts between frames
  assign hw_load = cs_high && !load_strobe_n_q[1];

  // one code pair per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge aclk) begin
      if (!aresetn || srst) begin
        in_q[i]  <= CODE_RST;
        out_q[i] <= CODE_RST;
      end else begin
        // input bank takes the code on both write commands
        if (exec && chm[i] && (cmd == QDAC_CMD_WR_IN || cmd == QDAC_CMD_WR_UPD)) begin
          in_q[i] <= code;
        end
        // output bank priority: frame command, then load pin, then soft load
        if (exec && chm[i] && cmd == QDAC_CMD_WR_UPD) begin
          out_q[i] <= code;
        end else if (exec && chm[i] && cmd == QDAC_CMD_UPD) begin
          out_q[i] <= in_q[i];
        end else if (exec && chm[i] && cmd == QDAC_CMD_WR_IN && hw_load && !lmask_q[i]) begin
          out_q[i] <= code;
        end else if ((hw_load && !lmask_q[i]) || swload) begin
          out_q[i] <= in_q[i];
        end
      end
    end
  end

  // mode registers; unlisted codes fall to default and hold
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      pwr_q    <= PWR_RST;
      lmask_q  <= LMASK_RST;
      ref_en_q <= REF_RST;
      chain_q  <= CHAIN_RST;
    end else if (exec) begin
      case (cmd)
        QDAC_CMD_PWR:   pwr_q    <= fw[PWR_W-1:0];
        QDAC_CMD_LMASK: lmask_q  <= fw[NCH-1:0];
        QDAC_CMD_REF:   ref_en_q <= ~fw[0];
        QDAC_CMD_CHAIN: chain_q  <= fw[0];
        default:        pwr_q    <= pwr_q;
      endcase
    end
  end

  // readback arms for exactly the next frame; lone mask bit picks channel
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      rb_arm_q <= 1'b0;
      rb_sel_q <= 2'd0;
    end else if (exec) begin
      rb_arm_q <= cmd == QDAC_CMD_RDBK;
      if (cmd == QDAC_CMD_RDBK) begin
        case (chm)
          4'h2:    rb_sel_q <= 2'd1;
          4'h4:    rb_sel_q <= 2'd2;
          4'h8:    rb_sel_q <= 2'd3;
          default: rb_sel_q <= 2'd0;  // none or several read channel a
        endcase
      end
    end
  end

  // executed frame count survives soft reset for diagnosis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_cnt_q <= 8'h00;
    end else if (exec) begin
      frm_cnt_q <= frm_cnt_q + 8'h01;
    end
  end

  // write channel: address and data taken together, one outstanding
  assign awready = awvalid && wvalid && !bvalid_q;
  assign wready  = awready;
  assign wr_fire = awready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awaddr == ADDR_CTRL) ? RESP_OK : RESP_ERR;  // only control is writable
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (araddr == ADDR_CTRL) begin
      rd_mux = 32'h0000_0000;                                   // control bits self-clear
    end else if (araddr == ADDR_STAT) begin
      rd_mux = {16'h0000, frm_cnt_q, 1'b0, rb_sel_q, load_strobe_n_q[1], rb_arm_q, gain_q[1], chain_q, ref_en_q};
    end else if (araddr == ADDR_PWR) begin
      rd_mux = {20'h00000, lmask_q, pwr_q};
    end else if (araddr[7:4] == PAGE_IN && araddr[1:0] == 2'b00) begin
      rd_mux = {16'h0000, in_q[araddr[3:2]]};
    end else if (araddr[7:4] == PAGE_OUT && araddr[1:0] == 2'b00) begin
      rd_mux = {16'h0000, out_q[araddr[3:2]]};
    end else begin
      rd_err = 1'b1;                                            // unmapped
    end
  end

  // read channel: one outstanding, answer one cycle after address
  assign arready = !rvalid_q;
  assign rd_fire = arvalid && arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OK;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_err ? RESP_ERR : RESP_OK;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign out_code     = out_q;
  assign power_mode   = pwr_q;
  assign ref_enable   = ref_en_q;
  assign gain_two     = gain_q[1];
  assign chain_enable = chain_q;

  chk_write_input: assert property (
    exec && cmd == QDAC_CMD_WR_IN && chm[0] && !srst |=> in_q[0] == $past(code))
    else $error("input write not stored");
  chk_update_copy: assert property (
    exec && cmd == QDAC_CMD_UPD && chm[0] && !srst |=> out_q[0] == $past(in_q[0]))
    else $error("update did not copy input");
  chk_write_update: assert property (
    exec && cmd == QDAC_CMD_WR_UPD && chm[2] && !srst |=> out_q[2] == $past(code) && in_q[2] == out_q[2])
    else $error("write and update mismatch");
  chk_hw_load: assert property (
    hw_load && !lmask_q[3] && !exec && !srst |=> out_q[3] == $past(in_q[3]))
    else $error("load pin did not transfer");
  // a masked channel must hold its output however long the pin stays low
  chk_mask_blocks: assert property (
    hw_load && lmask_q[2] && !exec && !swload && !srst |=> $stable(out_q[2]))
    else $error("masked channel followed the load pin");
  chk_readback_arm: assert property (
    exec && cmd == QDAC_CMD_RDBK && chm == 4'h2 && !srst |=> rb_arm_q && rb_sel_q == 2'd1)
    else $error("readback not armed for channel b");
  chk_reserved_hold: assert property (
    exec && cmd >= 4'hA && cmd <= 4'hE && !ctrl_wr |=> $stable(in_q) && $stable(pwr_q) && $stable(chain_q)
      && $stable(ref_en_q) && $stable(lmask_q))
    else $error("reserved code changed state");
  chk_chain_set: assert property (
    exec && cmd == QDAC_CMD_CHAIN && !ctrl_wr |=> chain_q == $past(fw[0]))
    else $error("chain mode not taken from bit zero");
  chk_power_bits: assert property (
    exec && cmd == QDAC_CMD_PWR && !ctrl_wr |=> power_mode == $past(fw[PWR_W-1:0]))
    else $error("power bits not stored");
  chk_soft_reset: assert property (
    exec && cmd == QDAC_CMD_SRST |=> in_q == '0 && out_q == '0 && ref_en_q && !chain_q && pwr_q == '0)
    else $error("soft reset left state");
  chk_ref_default: assert property (disable iff (1'b0)
    !aresetn |=> ref_en_q && !chain_q)
    else $error("reference not on after reset");
endmodule

/* File: pkg/qdac_pkg.sv */
package qdac_pkg;
  // serial frame layout
  localparam int FRAME_BITS = 24;            // bits per frame
  localparam int CMD_LSB    = 20;            // command nibble 23..20
  localparam int MASK_LSB   = 16;            // channel mask 19..16
  localparam int NCH        = 4;             // channels a..d
  localparam int DW         = 16;            // data word width
  localparam int RES_DEF    = 16;            // default resolution
  localparam int PWR_W      = 8;             // two power bits per channel
  localparam int PAD_W      = 4;             // bits in each pad nibble of readback word
  // command codes
  typedef enum logic [3:0] {
    QDAC_CMD_NOP    = 4'h0,
    QDAC_CMD_WR_IN  = 4'h1,
    QDAC_CMD_UPD    = 4'h2,
    QDAC_CMD_WR_UPD = 4'h3,
    QDAC_CMD_PWR    = 4'h4,
    QDAC_CMD_LMASK  = 4'h5,
    QDAC_CMD_SRST   = 4'h6,
    QDAC_CMD_REF    = 4'h7,
    QDAC_CMD_CHAIN  = 4'h8,
    QDAC_CMD_RDBK   = 4'h9,
    QDAC_CMD_NOP_DC = 4'hF
  } qdac_cmd_t;
  // reset values
  localparam logic [15:0] CODE_RST  = 16'h0000;
  localparam logic        REF_RST   = 1'b1;
  localparam logic        CHAIN_RST = 1'b0;
  localparam logic [7:0]  PWR_RST   = 8'h00;
  localparam logic [3:0]  LMASK_RST = 4'h0;
  // register bus map
  localparam int          AW        = 8;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;   // w: soft reset, soft load
  localparam logic [7:0]  ADDR_STAT = 8'h04;   // r: mode and pin state
  localparam logic [7:0]  ADDR_PWR  = 8'h08;   // r: power modes, load mask
  localparam logic [3:0]  PAGE_IN   = 4'h1;    // 0x10..0x1C input codes
  localparam logic [3:0]  PAGE_OUT  = 4'h2;    // 0x20..0x2C output codes
  localparam int          CTRL_SRST = 0;
  localparam int          CTRL_LOAD = 1;
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;
endpackage

/* File: tb/qdac_spi_host.sv */
`timescale 1ns/10ps
module qdac_spi_host (
  // clock used to pace the pins
  input  wire logic aclk,
  // pins toward the device
  output logic      frame_sel_n,
  output logic      serial_clk,
  output logic      serial_data_in,
  // device answer
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe
);
  localparam int HALF = 6; // aclk cycles per clock level, device needs three
  localparam int GAP  = 8; // select high time, well above 20 ns and the update delay

  // idle: select high, clock parked low
  initial begin
    frame_sel_n    = 1'b1;
    serial_clk     = 1'b0;
    serial_data_in = 1'b0;
  end

  // one frame of n bits, top bit first; answer bits taken at each falling clock
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] got);
    got = '0;
    @(posedge aclk);
    frame_sel_n <= 1'b0;
    repeat (HALF) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      serial_clk     <= 1'b1;
      serial_data_in <= w[23-i];
      repeat (HALF) @(posedge aclk);
      // an undriven output must not pass for data
      got        = {got[22:0], serial_data_out_oe ? serial_data_out : 1'bx};
      serial_clk <= 1'b0;
      repeat (HALF) @(posedge aclk);
    end
    frame_sel_n    <= 1'b1;
    serial_data_in <= ~serial_data_in; // released line shows no stale bit
    repeat (GAP) @(posedge aclk);
  endtask
endmodule

/* File: tb/quad_dac_serial_command_port_tb.sv */
`timescale 1ns/10ps
module quad_dac_serial_command_port_tb;
  import qdac_pkg::*;
  logic                   aclk, aresetn, load_strobe_n, gain_sel;
  wire logic              frame_sel_n, serial_clk, serial_data_in, serial_data_out, serial_data_out_oe;
  logic [NCH-1:0][DW-1:0] out_code;
  logic [PWR_W-1:0]       power_mode;
  logic                   ref_enable, gain_two, chain_enable;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic [AW-1:0]          awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  int                     error_cnt, samples_checked, cycles, frames, seed;
  logic [31:0]            rd_q[$];      // expected read data
  logic [1:0]             rr_q[$], br_q[$]; // expected responses
  logic [15:0]            in_m[NCH], out_m[NCH]; // expected code registers
  logic [23:0]            last_rb;      // bits seen on the answer line
  logic [15:0]            d;
  logic [7:0]             p;

  qdac_top DUT (.aclk(aclk), .aresetn(aresetn), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .load_strobe_n(load_strobe_n), .gain_sel(gain_sel), .out_code(out_code), .power_mode(power_mode),
    .ref_enable(ref_enable), .gain_two(gain_two), .chain_enable(chain_enable), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  qdac_spi_host host (.aclk(aclk), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // answer watcher: pops the oldest note whenever a response is taken, and cuts a hang short
  always @(posedge aclk) begin
    cycles++;
    if (rvalid && rready) begin
      check(rdata, rd_q.pop_front());
      check({30'h0, rresp}, {30'h0, rr_q.pop_front()});
    end
    if (bvalid && bready) check({30'h0, bresp}, {30'h0, br_q.pop_front()});
    if (cycles == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // register write: address and data together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    br_q.push_back(r);
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata  <= v;
    wstrb  <= 4'hF;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // register read, expectation noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OK);
    rd_q.push_back(e);
    rr_q.push_back(r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // full frame plus the expected effect on the code registers
  task automatic cmd_frame(input logic [3:0] c, input logic [3:0] m, input logic [15:0] v);
    host.send({c, m, v}, 24, last_rb);
    frames++;
    for (int i = 0; i < NCH; i++) begin
      if (m[i] && (c == 4'h1 || c == 4'h3)) in_m[i] = v;
      if (m[i] && (c == 4'h3 || (c == 4'h1 && !load_strobe_n))) out_m[i] = v;
      if (m[i] && c == 4'h2) out_m[i] = in_m[i];
    end
  endtask

  // status word: frame count, load pin, gain, chain, reference
  function automatic logic [31:0] stat_exp(input logic r, input logic c, input logic g);
    return {16'h0, frames[7:0], 3'b000, load_strobe_n, 1'b0, g, c, r};
  endfunction

  task automatic codes;
    for (int i = 0; i < NCH; i++) begin
      rd(8'h10 + 8'(4*i), {16'h0, in_m[i]});
      rd(8'h20 + 8'(4*i), {16'h0, out_m[i]});
      check({16'h0, out_code[i]}, {16'h0, out_m[i]});
    end
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, gain_sel} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    load_strobe_n = 1'b1;
    seed = 32'he85b;
    for (int i = 0; i < NCH; i++) {in_m[i], out_m[i]} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ADDR_STAT, stat_exp(1'b1, 1'b0, 1'b0));
    rd(8'h40, 32'h0, RESP_ERR);
    wr(ADDR_STAT, 32'h1, RESP_ERR);
    d = 16'($random(seed));
    cmd_frame(4'h1, 4'b0101, d);
    codes();
    cmd_frame(4'h2, 4'b0001, 16'h0);
    codes();
    // load pin while idle copies every input code out
    load_strobe_n <= 1'b0;
    repeat (5) @(posedge aclk);
    for (int i = 0; i < NCH; i++) out_m[i] = in_m[i];
    codes();
    cmd_frame(4'h1, 4'b0010, 16'($random(seed)));
    codes();
    load_strobe_n <= 1'b1;
    repeat (5) @(posedge aclk);
    cmd_frame(4'h3, 4'hF, 16'hFFFF);
    codes();
    // no-op and the reserved codes must leave every register but the frame count alone
    cmd_frame(4'h0, 4'hF, 16'h1234);
    for (int c = 10; c < 16; c++) cmd_frame(4'(c), 4'hF, 16'($random(seed)));
    codes();
    // short frame: bits land low, so the top of this word must not act as a write
    host.send(24'h3F5A00, 12, last_rb);
    frames++;
    codes();
    rd(ADDR_STAT, stat_exp(1'b1, 1'b0, 1'b0));
    p = 8'($random(seed));
    cmd_frame(4'h4, 4'h0, {8'h0, p});
    rd(ADDR_PWR, {24'h0, p});
    check({24'h0, power_mode}, {24'h0, p});
    cmd_frame(4'h7, 4'h0, 16'h0001);
    check({31'h0, ref_enable}, 32'h0);
    cmd_frame(4'h8, 4'h0, 16'h0001);
    check({31'h0, chain_enable}, 32'h1);
    gain_sel <= 1'b1;
    repeat (4) @(posedge aclk);
    check({31'h0, gain_two}, 32'h1);
    rd(ADDR_STAT, stat_exp(1'b0, 1'b1, 1'b1));
    cmd_frame(4'h6, 4'h0, 16'h0);
    for (int i = 0; i < NCH; i++) {in_m[i], out_m[i]} = '0;
    codes();
    check({22'h0, power_mode, ref_enable, chain_enable}, 32'h2);
    // readback of channel b during the following frame
    d = 16'($random(seed));
    cmd_frame(4'h3, 4'b0010, d);
    cmd_frame(4'h9, 4'b0010, 16'h0);
    cmd_frame(4'h0, 4'h0, 16'h0);
    check({8'h0, last_rb}, {8'h0, 4'h0, d, 4'h0});
    // load mask keeps channel c off the pin; control word loads and resets by software
    cmd_frame(4'h5, 4'h0, 16'h0004);
    rd(ADDR_PWR, 32'h0000_0400);
    d = 16'($random(seed));
    cmd_frame(4'h1, 4'hF, d);
    load_strobe_n <= 1'b0;
    repeat (5) @(posedge aclk);
    for (int i = 0; i < NCH; i++) if (i != 2) out_m[i] = in_m[i];
    codes();
    load_strobe_n <= 1'b1;
    repeat (5) @(posedge aclk);
    wr(ADDR_CTRL, 32'h2, RESP_OK);
    for (int i = 0; i < NCH; i++) out_m[i] = in_m[i];
    codes();
    wr(ADDR_CTRL, 32'h1, RESP_OK);
    for (int i = 0; i < NCH; i++) {in_m[i], out_m[i]} = '0;
    codes();
    rd(ADDR_PWR, 32'h0);
    repeat (10) @(posedge aclk);
    wrap_up();
  end
endmodule
